// [bidir_fifo_bus_match_flags.sv]
// two opposing fifos with port b bus matching and cross-port flag sync
`timescale 1ns/100ps

// Functional notes
// - no bus match: a b read shows the whole long word in place.
// - word size: two reads on the low half, ab then cd big endian, cd then ab little.
// - byte size: four reads on the low lane, abcd big endian, dcba little.
// - word size leaves the upper half undefined.
// - byte size leaves all but the low lane undefined.
// - byte order latches at master reset; match and size stay static.
// - fall-through: a write to empty fifo1 shows at port b within three b clocks.
// - narrow b: fifo1 out flag falls only on the last part of the last word.
// - standard: a write to empty fifo1 raises its b flag on the second b clock after it.
// - fall-through: a write to empty fifo2 shows at port a within three a clocks.
// - standard: a write to empty fifo2 raises its a flag on the second a clock after it.
// - narrow b: a fifo2 write counts only on the last part of a long word.
// - fall-through: a b read freeing full fifo1 raises a input ready on the second a clock.
// - standard: a b read freeing full fifo1 raises the a full flag on the second a clock.
// - narrow b: a fifo1 read frees space only on the last part of a long word.
// - narrow reads hold the rest of a word aside and fetch no new one.
module bidir_fifo_bus_match_flags #(
    parameter int AW = bidir_fifo_pkg::FIFO_AW
) (
    input wire logic sys_clk_i,
    input wire logic rst_b_i,
    input wire logic port_a_clock_en_i,
    input wire logic port_b_clock_en_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [bidir_fifo_pkg::APB_AW-1:0] paddr_i,
    input wire logic [bidir_fifo_pkg::APB_DW-1:0] pwdata_i,
    output logic [bidir_fifo_pkg::APB_DW-1:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic a_write_i,
    input wire logic [bidir_fifo_pkg::DATA_W-1:0] a_data_i,
    input wire logic a_read_i,
    output logic [bidir_fifo_pkg::DATA_W-1:0] a_data_o,
    input wire logic b_read_i,
    output logic [bidir_fifo_pkg::DATA_W-1:0] b_data_o,
    input wire logic b_write_i,
    input wire logic [bidir_fifo_pkg::DATA_W-1:0] b_data_i,
    output logic fifo1_output_ready_o,
    output logic fifo1_empty_flag_n_o,
    output logic fifo1_input_ready_o,
    output logic fifo1_full_flag_n_o,
    output logic fifo2_output_ready_o,
    output logic fifo2_empty_flag_n_o,
    output logic fifo2_input_ready_o,
    output logic fifo2_full_flag_n_o
);
    import bidir_fifo_pkg::*;

    localparam int DEPTH = 1 << AW;
    typedef logic [AW:0] ptr_t;
    localparam ptr_t PTR_ONE = ptr_t'(1);

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic ptr_t bin2gray(ptr_t b);
        return b ^ (b >> 1);
    endfunction

    function automatic ptr_t gray2bin(ptr_t g);
        ptr_t b;
        b = '0;
        b[AW] = g[AW];
        for (int i = AW - 1; i >= 0; i--) begin
            b[i] = b[i + 1] ^ g[i];
        end
        return b;
    endfunction

    function automatic logic is_full(ptr_t w, ptr_t r);
        return (w[AW] != r[AW]) && (w[AW-1:0] == r[AW-1:0]);
    endfunction

    function automatic logic [1:0] parts_m1(cfg_t c);
        if (!c.bus_match_select) begin
            return PARTS_LONG;
        end
        return c.size_byte ? PARTS_BYTE : PARTS_WORD;
    endfunction

    // lane index of part p; big endian takes the top lane first
    function automatic logic [1:0] lane_of(logic [1:0] p, cfg_t c);
        logic [1:0] idx;
        idx = PART_FIRST;
        if (c.size_byte) begin
            idx = c.byte_order_select ? (PARTS_BYTE - p) : p;
        end else begin
            idx = {1'b0, c.byte_order_select ? ~p[0] : p[0]};
        end
        return idx;
    endfunction

    // unused lanes are driven low, any value would do
    function automatic logic [DATA_W-1:0] part_out(logic [DATA_W-1:0] l, logic [1:0] p, cfg_t c);
        logic [DATA_W-1:0] o;
        o = '0;
        if (!c.bus_match_select) begin
            o = l;
        end else if (c.size_byte) begin
            o[LANE_W-1:0] = l[lane_of(p, c) * LANE_W +: LANE_W];
        end else begin
            o[HALF_W-1:0] = l[lane_of(p, c) * HALF_W +: HALF_W];
        end
        return o;
    endfunction

    function automatic logic [DATA_W-1:0] part_merge(logic [DATA_W-1:0] l, logic [DATA_W-1:0] d,
                                                     logic [1:0] p, cfg_t c);
        logic [DATA_W-1:0] o;
        o = l;
        if (!c.bus_match_select) begin
            o = d;
        end else if (c.size_byte) begin
            o[lane_of(p, c) * LANE_W +: LANE_W] = d[LANE_W-1:0];
        end else begin
            o[lane_of(p, c) * HALF_W +: HALF_W] = d[HALF_W-1:0];
        end
        return o;
    endfunction

    // ------------------------------------------------------------
    // apb registers
    // ------------------------------------------------------------
    cfg_t ctrl_q;
    logic order_q;
    logic first_word_fallthrough_mode_q;
    logic mreset;
    logic apb_wr;
    logic apb_setup;
    logic mapped;
    cfg_t act;
    flags_t status;
    logic [APB_DW-1:0] prdata_q;

    assign mapped = (paddr_i == CTRL_OFS) || (paddr_i == STATUS_OFS) || (paddr_i == MRESET_OFS);
    assign apb_wr = psel_i && penable_i && pwrite_i && mapped;
    assign apb_setup = psel_i && !penable_i;
    assign mreset = apb_wr && (paddr_i == MRESET_OFS) && pwdata_i[MRESET_BIT];
    assign pready_o = 1'b1;
    assign pslverr_o = psel_i && penable_i && !mapped;
    assign prdata_o = prdata_q;
    // size and bus match follow the register live, software keeps them still
    assign act = '{ctrl_q.bus_match_select, ctrl_q.size_byte, order_q, first_word_fallthrough_mode_q};

    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ctrl_q <= CTRL_RST;
        end else if (apb_wr && (paddr_i == CTRL_OFS)) begin
            ctrl_q <= cfg_t'(pwdata_i[CFG_W-1:0]);
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            order_q <= CTRL_RST.byte_order_select;
            first_word_fallthrough_mode_q <= CTRL_RST.first_word_fallthrough_mode;
        end else if (mreset) begin
            order_q <= ctrl_q.byte_order_select;
            first_word_fallthrough_mode_q <= ctrl_q.first_word_fallthrough_mode;
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            prdata_q <= '0;
        end else if (apb_setup) begin
            case (paddr_i)
                CTRL_OFS: prdata_q <= {{(APB_DW - CFG_W){1'b0}}, ctrl_q};
                STATUS_OFS: prdata_q <= {{(APB_DW - STATUS_W){1'b0}}, status};
                default: prdata_q <= '0;
            endcase
        end
    end

    // ------------------------------------------------------------
    // fifo1: port a writes, port b reads with bus matching
    // ------------------------------------------------------------
    logic [DATA_W-1:0] mem1 [DEPTH];
    ptr_t wptr1_q, wgray1_q, w1_meta_q, w1_sync_q;
    ptr_t rptr1_q, cptr1_q, cgray1_q, c1_meta_q, c1_sync_q;
    logic [DATA_W-1:0] out1_q, b_data_q;
    logic [1:0] part1_q, pm1;
    logic held1_q, last1, rd1, fetch1, commit1, wr1, nonempty1, full1, flag1;

    assign pm1 = parts_m1(act);
    assign nonempty1 = gray2bin(w1_sync_q) != rptr1_q;
    // space is handed back only when the last part leaves the holding register
    assign full1 = is_full(wptr1_q, gray2bin(c1_sync_q));
    assign wr1 = port_a_clock_en_i && a_write_i && !full1;
    assign last1 = part1_q == pm1;

    always_comb begin
        if (act.first_word_fallthrough_mode) begin
            rd1 = port_b_clock_en_i && b_read_i && held1_q;
            fetch1 = port_b_clock_en_i && nonempty1 && (!held1_q || (b_read_i && last1));
            commit1 = rd1 && last1;
        end else begin
            rd1 = port_b_clock_en_i && b_read_i && (held1_q || nonempty1);
            fetch1 = rd1 && !held1_q;
            commit1 = rd1 && (held1_q ? last1 : (pm1 == PARTS_LONG));
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (wr1) begin
            mem1[wptr1_q[AW-1:0]] <= a_data_i;
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            wptr1_q <= '0;
            wgray1_q <= '0;
        end else if (mreset) begin
            wptr1_q <= '0;
            wgray1_q <= '0;
        end else if (wr1) begin
            wptr1_q <= wptr1_q + PTR_ONE;
            wgray1_q <= bin2gray(wptr1_q + PTR_ONE);
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            w1_meta_q <= '0;
            w1_sync_q <= '0;
        end else if (mreset) begin
            w1_meta_q <= '0;
            w1_sync_q <= '0;
        end else if (port_b_clock_en_i) begin
            w1_meta_q <= wgray1_q;
            w1_sync_q <= w1_meta_q;
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            c1_meta_q <= '0;
            c1_sync_q <= '0;
        end else if (mreset) begin
            c1_meta_q <= '0;
            c1_sync_q <= '0;
        end else if (port_a_clock_en_i) begin
            c1_meta_q <= cgray1_q;
            c1_sync_q <= c1_meta_q;
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cptr1_q <= '0;
            cgray1_q <= '0;
        end else if (mreset) begin
            cptr1_q <= '0;
            cgray1_q <= '0;
        end else if (commit1) begin
            cptr1_q <= cptr1_q + PTR_ONE;
            cgray1_q <= bin2gray(cptr1_q + PTR_ONE);
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rptr1_q <= '0;
            out1_q <= '0;
            b_data_q <= '0;
            part1_q <= PART_FIRST;
            held1_q <= 1'b0;
        end else if (mreset) begin
            rptr1_q <= '0;
            part1_q <= PART_FIRST;
            held1_q <= 1'b0;
        end else if (fetch1) begin
            rptr1_q <= rptr1_q + PTR_ONE;
            out1_q <= mem1[rptr1_q[AW-1:0]];
            b_data_q <= part_out(mem1[rptr1_q[AW-1:0]], PART_FIRST, act);
            if (act.first_word_fallthrough_mode) begin
                part1_q <= PART_FIRST;
                held1_q <= 1'b1;
            end else begin
                part1_q <= PART_STEP;
                held1_q <= pm1 != PARTS_LONG;
            end
        end else if (rd1) begin
            if (act.first_word_fallthrough_mode) begin
                if (last1) begin
                    held1_q <= 1'b0;
                end else begin
                    part1_q <= part1_q + PART_STEP;
                    b_data_q <= part_out(out1_q, part1_q + PART_STEP, act);
                end
            end else begin
                b_data_q <= part_out(out1_q, part1_q, act);
                if (last1) begin
                    held1_q <= 1'b0;
                end else begin
                    part1_q <= part1_q + PART_STEP;
                end
            end
        end
    end

    assign b_data_o = b_data_q;
    // standard mode keeps the flag up while parts remain held
    assign flag1 = act.first_word_fallthrough_mode ? held1_q : (held1_q || nonempty1);
    assign fifo1_output_ready_o = act.first_word_fallthrough_mode && flag1;
    assign fifo1_empty_flag_n_o = !act.first_word_fallthrough_mode && flag1;
    assign fifo1_input_ready_o = act.first_word_fallthrough_mode && !full1;
    assign fifo1_full_flag_n_o = !act.first_word_fallthrough_mode && !full1;

    // ------------------------------------------------------------
    // fifo2: port b writes with packing, port a reads
    // ------------------------------------------------------------
    logic [DATA_W-1:0] mem2 [DEPTH];
    ptr_t wptr2_q, wgray2_q, w2_meta_q, w2_sync_q;
    ptr_t rptr2_q, rgray2_q, r2_meta_q, r2_sync_q;
    logic [DATA_W-1:0] pack2_q, merged2, a_data_q;
    logic [1:0] bpart2_q;
    logic wr2, push2, held2_q, rd2, fetch2, nonempty2, full2, flag2;

    assign full2 = is_full(wptr2_q, gray2bin(r2_sync_q));
    assign wr2 = port_b_clock_en_i && b_write_i && !full2;
    assign push2 = wr2 && (bpart2_q == pm1);
    assign merged2 = part_merge(pack2_q, b_data_i, bpart2_q, act);
    assign nonempty2 = gray2bin(w2_sync_q) != rptr2_q;

    always_comb begin
        if (act.first_word_fallthrough_mode) begin
            rd2 = port_a_clock_en_i && a_read_i && held2_q;
            fetch2 = port_a_clock_en_i && nonempty2 && (!held2_q || a_read_i);
        end else begin
            rd2 = port_a_clock_en_i && a_read_i && nonempty2;
            fetch2 = rd2;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (push2) begin
            mem2[wptr2_q[AW-1:0]] <= merged2;
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            pack2_q <= '0;
            bpart2_q <= PART_FIRST;
        end else if (mreset) begin
            bpart2_q <= PART_FIRST;
        end else if (push2) begin
            bpart2_q <= PART_FIRST;
        end else if (wr2) begin
            pack2_q <= merged2;
            bpart2_q <= bpart2_q + PART_STEP;
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            wptr2_q <= '0;
            wgray2_q <= '0;
        end else if (mreset) begin
            wptr2_q <= '0;
            wgray2_q <= '0;
        end else if (push2) begin
            wptr2_q <= wptr2_q + PTR_ONE;
            wgray2_q <= bin2gray(wptr2_q + PTR_ONE);
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            w2_meta_q <= '0;
            w2_sync_q <= '0;
            r2_meta_q <= '0;
            r2_sync_q <= '0;
        end else if (mreset) begin
            w2_meta_q <= '0;
            w2_sync_q <= '0;
            r2_meta_q <= '0;
            r2_sync_q <= '0;
        end else begin
            if (port_a_clock_en_i) begin
                w2_meta_q <= wgray2_q;
                w2_sync_q <= w2_meta_q;
            end
            if (port_b_clock_en_i) begin
                r2_meta_q <= rgray2_q;
                r2_sync_q <= r2_meta_q;
            end
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rptr2_q <= '0;
            rgray2_q <= '0;
            a_data_q <= '0;
            held2_q <= 1'b0;
        end else if (mreset) begin
            rptr2_q <= '0;
            rgray2_q <= '0;
            held2_q <= 1'b0;
        end else if (fetch2) begin
            rptr2_q <= rptr2_q + PTR_ONE;
            rgray2_q <= bin2gray(rptr2_q + PTR_ONE);
            a_data_q <= mem2[rptr2_q[AW-1:0]];
            held2_q <= act.first_word_fallthrough_mode;
        end else if (rd2) begin
            held2_q <= 1'b0;
        end
    end

    assign a_data_o = a_data_q;
    assign flag2 = act.first_word_fallthrough_mode ? held2_q : nonempty2;
    assign fifo2_output_ready_o = act.first_word_fallthrough_mode && flag2;
    assign fifo2_empty_flag_n_o = !act.first_word_fallthrough_mode && flag2;
    assign fifo2_input_ready_o = act.first_word_fallthrough_mode && !full2;
    assign fifo2_full_flag_n_o = !act.first_word_fallthrough_mode && !full2;

    assign status = '{held2_q, held1_q, order_q, first_word_fallthrough_mode_q, !full2, flag2, !full1, flag1};

endmodule

// [bidir_fifo_pkg.sv]
// constants, register map and types shared by the bidirectional fifo block
package bidir_fifo_pkg;

    // ------------------------------------------------------------
    // data path geometry
    // ------------------------------------------------------------
    localparam int DATA_W = 36;
    localparam int LANE_W = 9;
    localparam int HALF_W = 18;
    localparam int FIFO_AW = 8;
    localparam int APB_AW = 8;
    localparam int APB_DW = 32;

    // ------------------------------------------------------------
    // register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [APB_AW-1:0] CTRL_OFS = 8'h00;
    localparam logic [APB_AW-1:0] STATUS_OFS = 8'h04;
    localparam logic [APB_AW-1:0] MRESET_OFS = 8'h08;

    localparam int CTRL_FIRST_WORD_FALLTHROUGH_MODE_BIT = 0;
    localparam int CTRL_BE_BIT = 1;
    localparam int CTRL_SIZE_BIT = 2;
    localparam int CTRL_BM_BIT = 3;
    localparam int MRESET_BIT = 0;
    localparam int CFG_W = 4;
    localparam int STATUS_W = 8;

    // ------------------------------------------------------------
    // encodings and reset values
    // ------------------------------------------------------------
    localparam logic [1:0] PARTS_LONG = 2'h0;
    localparam logic [1:0] PARTS_WORD = 2'h1;
    localparam logic [1:0] PARTS_BYTE = 2'h3;
    localparam logic [1:0] PART_STEP = 2'h1;
    localparam logic [1:0] PART_FIRST = 2'h0;

    typedef struct packed {
        logic bus_match_select;
        logic size_byte;
        logic byte_order_select;
        logic first_word_fallthrough_mode;
    } cfg_t;

    localparam cfg_t CTRL_RST = '{1'b0, 1'b0, 1'b1, 1'b0};

    typedef struct packed {
        logic fifo2_held;
        logic fifo1_held;
        logic order_latched;
        logic first_word_fallthrough_mode_latched;
        logic fifo2_in_ok;
        logic fifo2_out_ok;
        logic fifo1_in_ok;
        logic fifo1_out_ok;
    } flags_t;

endpackage

// [port_tick_gen.sv]
// port clock tick model for the processors on both ports
`timescale 1ns/100ps
module port_tick_gen #(
    parameter int A_DIV = 3,
    parameter int B_DIV = 2
) (
    input wire logic sys_clk_i,
    input wire logic rst_b_i,
    output logic a_tick_o,
    output logic b_tick_o
);
    int a_cnt_q;
    int b_cnt_q;
    // coprime dividers of one clock so tick phases shift and, with the default dividers, coincide every sixth clock
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            a_cnt_q <= 0;
        end else begin
            a_cnt_q <= (a_cnt_q == A_DIV - 1) ? 0 : a_cnt_q + 1;
        end
    end
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            b_cnt_q <= 0;
        end else begin
            b_cnt_q <= (b_cnt_q == B_DIV - 1) ? 0 : b_cnt_q + 1;
        end
    end
    assign a_tick_o = rst_b_i && (a_cnt_q == A_DIV - 1);
    assign b_tick_o = rst_b_i && (b_cnt_q == B_DIV - 1);
endmodule

// [fifo_flags_check_asserts.sv]
// concurrent checks on the fifo block ports
`timescale 1ns/100ps
module fifo_flags_check (
    input wire logic sys_clk_i,
    input wire logic rst_b_i,
    input wire logic port_a_clock_en_i,
    input wire logic port_b_clock_en_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic pslverr_o,
    input wire logic b_read_i,
    input wire logic [bidir_fifo_pkg::DATA_W-1:0] b_data_o,
    input wire logic [bidir_fifo_pkg::DATA_W-1:0] a_data_o,
    input wire logic fifo1_output_ready_o,
    input wire logic fifo1_empty_flag_n_o,
    input wire logic fifo1_input_ready_o,
    input wire logic fifo1_full_flag_n_o,
    input wire logic fifo2_output_ready_o,
    input wire logic fifo2_empty_flag_n_o
);
    import bidir_fifo_pkg::*;
    logic wr_w;
    // any register write may be a master reset, which may move every flag
    assign wr_w = psel_i && penable_i && pwrite_i;
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (!rst_b_i);
    a_f1_out_rise: assert property ($rose(fifo1_empty_flag_n_o) |-> $past(port_b_clock_en_i))
        else $error("f1 empty rise");
    a_f1_rdy_rise: assert property ($rose(fifo1_output_ready_o) |-> $past(port_b_clock_en_i))
        else $error("f1 ready rise");
    a_f2_out_rise: assert property ($rose(fifo2_empty_flag_n_o) |-> $past(port_a_clock_en_i))
        else $error("f2 empty rise");
    a_f2_rdy_rise: assert property ($rose(fifo2_output_ready_o) |-> $past(port_a_clock_en_i))
        else $error("f2 ready rise");
    a_out_fall: assert property ($fell(fifo1_empty_flag_n_o || fifo1_output_ready_o)
        |-> $past(b_read_i && port_b_clock_en_i) || $past(wr_w))
        else $error("f1 out fall");
    a_space_rise: assert property ($rose(fifo1_full_flag_n_o || fifo1_input_ready_o)
        |-> $past(port_a_clock_en_i) || $past(wr_w))
        else $error("f1 space rise");
    a_bdata_hold: assert property ($changed(b_data_o) |-> $past(port_b_clock_en_i) || $past(wr_w))
        else $error("b data moved");
    a_adata_hold: assert property ($changed(a_data_o) |-> $past(port_a_clock_en_i) || $past(wr_w))
        else $error("a data moved");
    a_mode_excl: assert property (!(fifo1_output_ready_o && fifo1_empty_flag_n_o))
        else $error("f1 out modes");
    a_in_excl: assert property (!(fifo1_input_ready_o && fifo1_full_flag_n_o))
        else $error("f1 in modes");
    a_err_access: assert property (pslverr_o |-> psel_i && penable_i)
        else $error("stray slverr");
    c_f1_out: cover property ($rose(fifo1_empty_flag_n_o));
    c_f1_rdy: cover property ($rose(fifo1_output_ready_o));
    c_space: cover property ($rose(fifo1_full_flag_n_o));
endmodule

// [tb_top.sv]
// self-checking bench for the bidirectional fifo block
`timescale 1ns/100ps
module tb_top;
    import bidir_fifo_pkg::*;
    logic sys_clk_i = 1'h0;
    logic rst_b_i = 1'h0;
    logic port_a_clock_en_i, port_b_clock_en_i, pready_o, pslverr_o, err;
    logic psel_i = 1'h0, penable_i = 1'h0, pwrite_i = 1'h0;
    logic [APB_AW-1:0] paddr_i = '0;
    logic [APB_DW-1:0] pwdata_i = '0, prdata_o, rd;
    logic a_write_i = 1'h0, a_read_i = 1'h0, b_read_i = 1'h0, b_write_i = 1'h0;
    logic [DATA_W-1:0] a_data_i = '0, b_data_i = '0, a_data_o, b_data_o;
    logic fifo1_output_ready_o, fifo1_empty_flag_n_o, fifo1_input_ready_o, fifo1_full_flag_n_o;
    logic fifo2_output_ready_o, fifo2_empty_flag_n_o, fifo2_input_ready_o, fifo2_full_flag_n_o;
    logic [DATA_W-1:0] w = 36'h9A2B4C6D8;
    int n_mismatch = 0;
    int comparisons = 0;
    always #2.5 sys_clk_i = ~sys_clk_i;
    bidir_fifo_bus_match_flags #(.AW(2)) u_dut (.*);
    port_tick_gen u_ticks (.sys_clk_i, .rst_b_i, .a_tick_o(port_a_clock_en_i), .b_tick_o(port_b_clock_en_i));
    // ------------------------------------------------------------
    // bus and port drivers
    // ------------------------------------------------------------
    task automatic chk(input string name, input logic [DATA_W-1:0] exp, input logic [DATA_W-1:0] got);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic apb(input logic wr, input logic [APB_AW-1:0] a, input logic [APB_DW-1:0] d);
        @(posedge sys_clk_i);
        psel_i <= 1'h1;
        pwrite_i <= wr;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge sys_clk_i);
        penable_i <= 1'h1;
        do @(posedge sys_clk_i); while (pready_o !== 1'h1);
        rd = prdata_o;
        err = pslverr_o;
        psel_i <= 1'h0;
        penable_i <= 1'h0;
    endtask
    // order and fall-through latch at the master reset; size and match follow the ctrl write
    task automatic mode(input logic [3:0] cfg);
        apb(1'h1, CTRL_OFS, {28'h0, cfg});
        apb(1'h1, MRESET_OFS, 32'h1);
    endtask
    task automatic a_edge;
        do @(posedge sys_clk_i); while (port_a_clock_en_i !== 1'h1);
    endtask
    task automatic b_edge;
        do @(posedge sys_clk_i); while (port_b_clock_en_i !== 1'h1);
    endtask
    task automatic push_a(input logic [DATA_W-1:0] d);
        @(posedge sys_clk_i);
        a_write_i <= 1'h1;
        a_data_i <= d;
        a_edge();
        a_write_i <= 1'h0;
    endtask
    task automatic push_b(input logic [DATA_W-1:0] d);
        @(posedge sys_clk_i);
        b_write_i <= 1'h1;
        b_data_i <= d;
        b_edge();
        b_write_i <= 1'h0;
    endtask
    task automatic rd_b;
        repeat (60) if ((fifo1_empty_flag_n_o | fifo1_output_ready_o) !== 1'h1) @(posedge sys_clk_i);
        @(posedge sys_clk_i);
        b_read_i <= 1'h1;
        b_edge();
        b_read_i <= 1'h0;
        #1;
    endtask
    task automatic pull_b(input logic [DATA_W-1:0] exp);
        rd_b();
        chk("b_data", exp, b_data_o);
    endtask
    task automatic pull_a(input logic [DATA_W-1:0] exp);
        repeat (60) if ((fifo2_empty_flag_n_o | fifo2_output_ready_o) !== 1'h1) @(posedge sys_clk_i);
        @(posedge sys_clk_i);
        a_read_i <= 1'h1;
        a_edge();
        a_read_i <= 1'h0;
        #1 chk("a_data", exp, a_data_o);
    endtask
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_regs;
        apb(1'h0, CTRL_OFS, 32'h0);
        chk("ctrl", {32'h0, CTRL_RST}, rd);
        chk("pready", 36'h1, pready_o);
        apb(1'h0, 8'h0C, 32'h0);
        chk("unmapped", 36'h0, rd);
        chk("slverr", 36'h1, err);
    endtask
    task automatic t_long;
        mode(4'h0);
        push_a(w);
        pull_b(w);
        chk("f1_empty_n", 36'h0, fifo1_empty_flag_n_o);
    endtask
    task automatic t_word;
        for (int big = 0; big < 2; big++) begin
            mode(big ? 4'hA : 4'h8);
            push_a(w);
            pull_b(big ? {18'h0, w[35:18]} : {18'h0, w[17:0]});
            chk("f1_empty_n", 36'h1, fifo1_empty_flag_n_o);
            pull_b(big ? {18'h0, w[17:0]} : {18'h0, w[35:18]});
            chk("f1_empty_n", 36'h0, fifo1_empty_flag_n_o);
        end
    endtask
    task automatic t_byte;
        for (int big = 0; big < 2; big++) begin
            mode(big ? 4'hE : 4'hC);
            push_a(w);
            for (int i = 0; i < 4; i++) begin
                pull_b({27'h0, w[35 - 9 * (big ? i : 3 - i) -: 9]});
                chk("f1_empty_n", (i < 3) ? 36'h1 : 36'h0, fifo1_empty_flag_n_o);
            end
        end
    endtask
    // depth of four long words; a fifth write must be dropped
    task automatic t_full;
        mode(4'hA);
        for (int k = 1; k < 6; k++) push_a({4{k[8:0]}});
        #1 chk("f1_full_n", 36'h0, fifo1_full_flag_n_o);
        pull_b({18'h0, 9'h1, 9'h1});
        repeat (12) @(posedge sys_clk_i);
        #1 chk("f1_full_n", 36'h0, fifo1_full_flag_n_o);
        pull_b({18'h0, 9'h1, 9'h1});
        repeat (20) if (fifo1_full_flag_n_o !== 1'h1) @(posedge sys_clk_i);
        chk("f1_full_n", 36'h1, fifo1_full_flag_n_o);
        for (int k = 2; k < 5; k++) begin
            pull_b({18'h0, k[8:0], k[8:0]});
            pull_b({18'h0, k[8:0], k[8:0]});
        end
        chk("f1_empty_n", 36'h0, fifo1_empty_flag_n_o);
    endtask
    task automatic t_fifo2;
        push_b({18'h0, w[35:18]});
        repeat (20) @(posedge sys_clk_i);
        #1 chk("f2_empty_n", 36'h0, fifo2_empty_flag_n_o);
        push_b({18'h0, w[17:0]});
        pull_a(w);
        chk("f2_full_n", 36'h1, fifo2_full_flag_n_o);
    endtask
    task automatic t_fall_through;
        mode(4'hB);
        push_a(w);
        repeat (60) if (fifo1_output_ready_o !== 1'h1) @(posedge sys_clk_i);
        #1 chk("f1_ready", 36'h1, fifo1_output_ready_o);
        chk("b_data", {18'h0, w[35:18]}, b_data_o);
        pull_b({18'h0, w[17:0]});
        chk("f1_ready", 36'h1, fifo1_output_ready_o);
        rd_b();
        chk("f1_ready", 36'h0, fifo1_output_ready_o);
        chk("f1_in_rdy", 36'h1, fifo1_input_ready_o);
        push_b({18'h0, w[35:18]});
        push_b({18'h0, w[17:0]});
        repeat (60) if (fifo2_output_ready_o !== 1'h1) @(posedge sys_clk_i);
        #1 chk("a_data", w, a_data_o);
    endtask
    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    initial begin
        #200000;
        n_mismatch++;
        give_verdict();
    end
    initial begin
        repeat (6) @(posedge sys_clk_i);
        rst_b_i <= 1'h1;
        t_regs();
        t_long();
        t_word();
        t_byte();
        t_full();
        t_fifo2();
        t_fall_through();
        give_verdict();
    end
endmodule
bind bidir_fifo_bus_match_flags fifo_flags_check u_chk (.*);
